// ===== ccr_pkg.sv
// constants for the charger control register pair three and four
package ccr_pkg;
  // ************************************
  // register offsets
  // ************************************
  localparam logic [7:0] CCR_OFS_CTRL_THREE = 8'h12;
  localparam logic [7:0] CCR_OFS_CTRL_FOUR  = 8'h13;
  // ************************************
  // control register three fields
  // ************************************
  localparam int CCR_B3_DRIVERS_OFF  = 7;
  localparam int CCR_B3_PULSE_OFF    = 4;
  localparam int CCR_B3_SHIP_HOLD    = 3;
  localparam int CCR_B3_LINEAR_OFF   = 2;
  localparam int CCR_B3_AUDIO_OFF    = 0;
  // ************************************
  // control register four fields
  // ************************************
  localparam int CCR_B4_DRIVER_TWO   = 7;
  localparam int CCR_B4_DRIVER_ONE   = 6;
  localparam int CCR_B4_RATE_SELECT  = 5;
  localparam int CCR_B4_INDICATOR    = 4;
  localparam int CCR_B4_HICCUP_OFF   = 3;
  localparam int CCR_B4_FORCE_DETECT = 1;
  localparam int CCR_B4_OCP_ON       = 0;
  // ************************************
  // reset values
  // ************************************
  localparam logic       CCR_RST_ZERO      = 1'b0;
  localparam logic       CCR_RST_OCP_ON    = 1'b1;
  localparam logic [7:0] CCR_RST_LIMIT     = 8'h00;
  // ************************************
  // timing
  // ************************************
  localparam int CCR_CLK_HZ          = 100000000;
  localparam int CCR_HOLD_LONG_MS    = 1000;
  localparam int CCR_HOLD_SHORT_MS   = 15;
  localparam int CCR_HOLD_LONG_CYC   = CCR_HOLD_LONG_MS * (CCR_CLK_HZ / 1000);
  localparam int CCR_HOLD_SHORT_CYC  = CCR_HOLD_SHORT_MS * (CCR_CLK_HZ / 1000);
  localparam int CCR_HOLD_CNT_W      = 27;
  localparam logic [1:0] CCR_POR_SETTLE = 2'h3;
  // ************************************
  // detection sequence states
  // ************************************
  typedef enum logic [1:0] {
    CCR_DET_IDLE,
    CCR_DET_STOP,
    CCR_DET_MEASURE
  } ccr_det_state_t;
endpackage

// ===== ccr_regs.sv
// charger control registers three and four with detection and ship-exit timing
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - drivers-off bit forces both driver enables low
// - pulse-mode-off bit, cleared only by register reset
// - ship exit hold: 1 s or 15 ms
// - linear-mode-off cleared by watchdog or reset
// - out-of-audio-off cleared only by register reset
// - driver two locked low without FET pair
// - driver one locked low without FET pair
// - rate select powers up from strap pin
// - indicator-off cleared by watchdog or reset
// - hiccup-off cleared by register reset
// - force detect accepted only above minimum voltage
// - detection stops switching, measures, updates limit
// - force detect self-clears when detection completes
// - overcurrent guard resets to on
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int          HOLD_LONG_CYC  = CCR_HOLD_LONG_CYC,
  parameter int          HOLD_SHORT_CYC = CCR_HOLD_SHORT_CYC,
  parameter int          LIMIT_W        = 8
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire logic               register_reset,
  input  wire logic               watchdog_expired,
  input  wire logic               strap_pin,
  input  wire logic               fet_pair_one_present,
  input  wire logic               fet_pair_two_present,
  input  wire logic               battery_above_minimum_system_voltage,
  input  wire logic               wake_button_pin_b,
  input  wire logic               ship_mode_active,
  input  wire logic               input_current_zero,
  input  wire logic               adc_done,
  input  wire logic [LIMIT_W-1:0] adc_vbus,
  output logic                    selector_driver_one_on,
  output logic                    selector_driver_two_on,
  output logic                    light_load_pulse_mode_off,
  output logic                    precharge_linear_mode_off,
  output logic                    out_of_audio_off,
  output logic                    switching_rate_select,
  output logic                    indicator_pin_off,
  output logic                    rail_short_hiccup_off,
  output logic                    input_overcurrent_guard_on,
  output logic                    converter_stop,
  output logic                    adc_start,
  output logic [LIMIT_W-1:0]      input_voltage_regulation_limit,
  output logic                    ship_exit
);
  // ************************************
  // input synchronisers
  // ************************************
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
    end else begin
      sync1_reg <= {wake_button_pin_b, battery_above_minimum_system_voltage,
                    fet_pair_two_present, fet_pair_one_present, strap_pin};
      sync2_reg <= sync1_reg;
    end
  end
  wire strap_s   = sync2_reg[0];
  wire pair_one  = sync2_reg[1];
  wire pair_two  = sync2_reg[2];
  wire vbat_ok   = sync2_reg[3];
  wire wake_b_s  = sync2_reg[4];

  // ************************************
  // power-on capture of straps
  // ************************************
  logic [1:0] por_cnt_reg;
  logic       por_done_reg;
  logic       strap_val_reg;
  logic       one_ok_reg;
  logic       two_ok_reg;
  wire        por_capture = !por_done_reg && (por_cnt_reg == CCR_POR_SETTLE);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_reg   <= 2'h0;
      por_done_reg  <= 1'b0;
      strap_val_reg <= CCR_RST_ZERO;
      one_ok_reg    <= 1'b0;
      two_ok_reg    <= 1'b0;
    end else if (!por_done_reg) begin
      por_cnt_reg <= por_cnt_reg + 2'h1;
      if (por_capture) begin
        por_done_reg  <= 1'b1;
        strap_val_reg <= strap_s;
        one_ok_reg    <= pair_one;
        two_ok_reg    <= pair_two;
      end
    end
  end

  // ************************************
  // write decode
  // ************************************
  wire wr3 = reg_wr && (reg_addr == CCR_OFS_CTRL_THREE);
  wire wr4 = reg_wr && (reg_addr == CCR_OFS_CTRL_FOUR);
  logic drv_off_reg;
  logic pulse_off_reg;
  logic ship_hold_reg;
  logic linear_off_reg;
  logic audio_off_reg;
  logic drv_two_reg;
  logic drv_one_reg;
  logic rate_reg;
  logic ind_off_reg;
  logic hiccup_off_reg;
  logic force_det_reg;
  logic ocp_on_reg;
  ccr_det_state_t det_state_reg;
  ccr_det_state_t det_state_next;
  wire det_finish = (det_state_reg == CCR_DET_MEASURE) && adc_done;

  wire drv_off_next = wr3 ? reg_wdata[CCR_B3_DRIVERS_OFF] : drv_off_reg;
  wire drv_one_next = !drv_off_next && one_ok_reg &&
                      (wr4 ? reg_wdata[CCR_B4_DRIVER_ONE] : drv_one_reg);
  wire drv_two_next = !drv_off_next && two_ok_reg &&
                      (wr4 ? reg_wdata[CCR_B4_DRIVER_TWO] : drv_two_reg);
  wire force_set    = wr4 && reg_wdata[CCR_B4_FORCE_DETECT] && vbat_ok;

  // ************************************
  // control fields
  // ************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_off_reg    <= CCR_RST_ZERO;
      drv_one_reg    <= CCR_RST_ZERO;
      drv_two_reg    <= CCR_RST_ZERO;
      pulse_off_reg  <= CCR_RST_ZERO;
      ship_hold_reg  <= CCR_RST_ZERO;
      linear_off_reg <= CCR_RST_ZERO;
      audio_off_reg  <= CCR_RST_ZERO;
      rate_reg       <= CCR_RST_ZERO;
      ind_off_reg    <= CCR_RST_ZERO;
      hiccup_off_reg <= CCR_RST_ZERO;
      force_det_reg  <= CCR_RST_ZERO;
      ocp_on_reg     <= CCR_RST_OCP_ON;
    end else begin
      drv_off_reg <= drv_off_next;
      drv_one_reg <= drv_one_next;
      drv_two_reg <= drv_two_next;
      if (por_capture || register_reset) begin
        rate_reg <= por_capture ? strap_s : strap_val_reg;
      end else if (wr4) begin
        rate_reg <= reg_wdata[CCR_B4_RATE_SELECT];
      end
      if (register_reset) begin
        pulse_off_reg  <= CCR_RST_ZERO;
        ship_hold_reg  <= CCR_RST_ZERO;
        linear_off_reg <= CCR_RST_ZERO;
        audio_off_reg  <= CCR_RST_ZERO;
        ind_off_reg    <= CCR_RST_ZERO;
        hiccup_off_reg <= CCR_RST_ZERO;
        force_det_reg  <= CCR_RST_ZERO;
        ocp_on_reg     <= CCR_RST_OCP_ON;
      end else begin
        if (wr3) begin
          pulse_off_reg <= reg_wdata[CCR_B3_PULSE_OFF];
          ship_hold_reg <= reg_wdata[CCR_B3_SHIP_HOLD];
          audio_off_reg <= reg_wdata[CCR_B3_AUDIO_OFF];
        end
        if (wr4) begin
          hiccup_off_reg <= reg_wdata[CCR_B4_HICCUP_OFF];
          ocp_on_reg     <= reg_wdata[CCR_B4_OCP_ON];
        end
        // watchdog clears only its own fields, other fields keep their value
        if (watchdog_expired) begin
          linear_off_reg <= CCR_RST_ZERO;
          ind_off_reg    <= CCR_RST_ZERO;
        end else begin
          if (wr3) linear_off_reg <= reg_wdata[CCR_B3_LINEAR_OFF];
          if (wr4) ind_off_reg <= reg_wdata[CCR_B4_INDICATOR];
        end
        if (force_set) begin
          force_det_reg <= 1'b1;
        end else if (det_finish) begin
          force_det_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************
  // forced input limit detection
  // ************************************
  always_comb begin
    det_state_next = det_state_reg;
    case (det_state_reg)
      CCR_DET_IDLE:    if (force_det_reg) det_state_next = CCR_DET_STOP;
      CCR_DET_STOP:    if (input_current_zero) det_state_next = CCR_DET_MEASURE;
      CCR_DET_MEASURE: if (adc_done) det_state_next = CCR_DET_IDLE;
      default:         det_state_next = CCR_DET_IDLE;
    endcase
    if (register_reset) det_state_next = CCR_DET_IDLE;
  end
  wire det_start_meas = (det_state_reg == CCR_DET_STOP) && input_current_zero;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      det_state_reg                  <= CCR_DET_IDLE;
      converter_stop                 <= 1'b0;
      adc_start                      <= 1'b0;
      input_voltage_regulation_limit <= CCR_RST_LIMIT[LIMIT_W-1:0];
    end else begin
      det_state_reg  <= det_state_next;
      converter_stop <= (det_state_next != CCR_DET_IDLE);
      adc_start      <= det_start_meas && !register_reset;
      if (det_finish && !register_reset) begin
        input_voltage_regulation_limit <= adc_vbus;
      end
    end
  end

  // ************************************
  // ship mode exit timer
  // ************************************
  logic [CCR_HOLD_CNT_W-1:0] hold_cnt_reg;
  wire  [CCR_HOLD_CNT_W-1:0] hold_need = ship_hold_reg ?
                                         CCR_HOLD_CNT_W'(HOLD_SHORT_CYC) : CCR_HOLD_CNT_W'(HOLD_LONG_CYC);
  wire  hold_hit = ship_mode_active && !wake_b_s && (hold_cnt_reg == hold_need - CCR_HOLD_CNT_W'(1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_reg <= '0;
      ship_exit    <= 1'b0;
    end else begin
      ship_exit <= hold_hit;
      if (!ship_mode_active || wake_b_s || hold_hit) begin
        hold_cnt_reg <= '0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + CCR_HOLD_CNT_W'(1);
      end
    end
  end

  // ************************************
  // read back and field outputs
  // ************************************
  wire [7:0] rd_three = {drv_off_reg, 2'h0, pulse_off_reg, ship_hold_reg,
                         linear_off_reg, 1'b0, audio_off_reg};
  wire [7:0] rd_four  = {drv_two_reg, drv_one_reg, rate_reg, ind_off_reg,
                         hiccup_off_reg, 1'b0, force_det_reg, ocp_on_reg};
  wire [7:0] rd_mux   = (reg_addr == CCR_OFS_CTRL_THREE) ? rd_three :
                        (reg_addr == CCR_OFS_CTRL_FOUR)  ? rd_four  : 8'h00;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end
  assign selector_driver_one_on     = drv_one_reg;
  assign selector_driver_two_on     = drv_two_reg;
  assign light_load_pulse_mode_off  = pulse_off_reg;
  assign precharge_linear_mode_off  = linear_off_reg;
  assign out_of_audio_off           = audio_off_reg;
  assign switching_rate_select      = rate_reg;
  assign indicator_pin_off          = ind_off_reg;
  assign rail_short_hiccup_off      = hiccup_off_reg;
  assign input_overcurrent_guard_on = ocp_on_reg;

  // ************************************
  // checks
  // ************************************
  chk_drivers_forced_off: assert property (@(posedge clk) disable iff (!rst_b)
    drv_off_reg |-> !drv_one_reg && !drv_two_reg) else $error("driver on while drivers off");
  chk_driver_one_lock: assert property (@(posedge clk) disable iff (!rst_b)
    (por_done_reg && !one_ok_reg) |-> !drv_one_reg) else $error("driver one set without fet pair");
  chk_driver_two_lock: assert property (@(posedge clk) disable iff (!rst_b)
    (por_done_reg && !two_ok_reg) |-> !drv_two_reg) else $error("driver two set without fet pair");
  chk_watchdog_keeps_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    (watchdog_expired && !register_reset && !wr3) |=> $stable(pulse_off_reg) && !linear_off_reg && !ind_off_reg)
    else $error("watchdog field handling wrong");
  chk_force_needs_vbat: assert property (@(posedge clk) disable iff (!rst_b)
    (!force_det_reg && !vbat_ok) |=> !force_det_reg) else $error("force detect set below minimum");
  chk_detect_updates: assert property (@(posedge clk) disable iff (!rst_b)
    (det_finish && !register_reset) |=> input_voltage_regulation_limit == $past(adc_vbus) &&
    (!force_det_reg || $past(force_set))) else $error("limit not updated or force not cleared");
  chk_stop_during_meas: assert property (@(posedge clk) disable iff (!rst_b)
    (det_state_reg == CCR_DET_MEASURE) |-> converter_stop) else $error("switching during measurement");
  chk_reset_restores_ocp: assert property (@(posedge clk) disable iff (!rst_b)
    register_reset |=> ocp_on_reg && !pulse_off_reg && !audio_off_reg && !hiccup_off_reg)
    else $error("register reset values wrong");
  chk_rate_from_strap: assert property (@(posedge clk) disable iff (!rst_b)
    por_capture |=> rate_reg == $past(strap_s)) else $error("rate not taken from strap");
  chk_ship_exit_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ship_exit |-> $past(hold_cnt_reg) == hold_need - CCR_HOLD_CNT_W'(1)) else $error("ship exit at wrong time");
  cov_detect_done: cover property (@(posedge clk) disable iff (!rst_b) det_finish);
  cov_ship_exit: cover property (@(posedge clk) disable iff (!rst_b) ship_exit);
  cov_driver_forced: cover property (@(posedge clk) disable iff (!rst_b) drv_off_reg ##1 !drv_off_reg ##1 drv_one_reg);
  cov_watchdog: cover property (@(posedge clk) disable iff (!rst_b) watchdog_expired && ind_off_reg);
endmodule
`default_nettype wire

// ===== ccr_regs_tb.sv
// self-checking testbench for the charger control register pair
`timescale 1ns/1ns
`default_nettype none
module ccr_regs_tb;
  import ccr_pkg::*;
  localparam int HOLD_L = 40;
  localparam int HOLD_S = 10;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       register_reset = 1'b0;
  logic       watchdog_expired = 1'b0;
  logic       strap_pin = 1'b1;
  logic       pair_one = 1'b1;
  logic       pair_two = 1'b0;
  logic       batt_ok = 1'b0;
  logic       wake_pin_b = 1'b1;
  logic       ship_mode = 1'b0;
  logic       cur_zero = 1'b0;
  logic       adc_done = 1'b0;
  logic [7:0] adc_vbus = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] limit;
  logic       drv_one, drv_two, pulse_off, linear_off, audio_off, rate_sel;
  logic       ind_off, hiccup_off, ocp_on, conv_stop, adc_start, ship_exit;
  wire  [7:0] pins = {pulse_off, linear_off, audio_off, ind_off, hiccup_off, ocp_on, rate_sel, drv_two};
  int         n_errors = 0;
  int         cmp_count = 0;

  always #5 clk = ~clk;

  ccr_regs #(.HOLD_LONG_CYC(HOLD_L), .HOLD_SHORT_CYC(HOLD_S), .LIMIT_W(8)) uut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .register_reset(register_reset),
    .watchdog_expired(watchdog_expired), .strap_pin(strap_pin), .fet_pair_one_present(pair_one),
    .fet_pair_two_present(pair_two), .battery_above_minimum_system_voltage(batt_ok),
    .wake_button_pin_b(wake_pin_b), .ship_mode_active(ship_mode), .input_current_zero(cur_zero),
    .adc_done(adc_done), .adc_vbus(adc_vbus), .selector_driver_one_on(drv_one),
    .selector_driver_two_on(drv_two), .light_load_pulse_mode_off(pulse_off),
    .precharge_linear_mode_off(linear_off), .out_of_audio_off(audio_off),
    .switching_rate_select(rate_sel), .indicator_pin_off(ind_off), .rail_short_hiccup_off(hiccup_off),
    .input_overcurrent_guard_on(ocp_on), .converter_stop(conv_stop), .adc_start(adc_start),
    .input_voltage_regulation_limit(limit), .ship_exit(ship_exit));

  // ************************************
  // report and compare
  // ************************************
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ************************************
  // register port access
  // ************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // let the write edge settle before anyone looks at the fields
    #1;
  endtask

  task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(name, exp, reg_rdata);
  endtask

  // one-cycle watchdog (wd=1) or register reset (wd=0) pulse
  task automatic pulse_src(input logic wd);
    @(posedge clk);
    if (wd) begin
      watchdog_expired <= 1'b1;
    end else begin
      register_reset <= 1'b1;
    end
    @(posedge clk);
    watchdog_expired <= 1'b0;
    register_reset <= 1'b0;
  endtask

  // bounded wait: 0 stop high, 1 adc start, 2 ship exit, 3 stop low
  task automatic wait_for(input int which, input int bound, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clk);
      #1;
      n++;
      case (which)
        0: hit = (conv_stop === 1'b1);
        1: hit = (adc_start === 1'b1);
        2: hit = (ship_exit === 1'b1);
        default: hit = (conv_stop === 1'b0);
      endcase
      if (!hit && n >= bound) begin
        n_errors++;
        $display("mismatch wait %0d expected event seen none", which);
        print_verdict();
      end
    end
  endtask

  task automatic ship_try(input logic [7:0] r3, input int hold);
    int n;
    wr(CCR_OFS_CTRL_THREE, r3);
    @(posedge clk);
    ship_mode <= 1'b1;
    wake_pin_b <= 1'b0;
    wait_for(2, hold + 20, n);
    check("ship exit delay", 8'h01, {7'h00, (n >= hold) && (n <= hold + 5)});
    @(posedge clk);
    wake_pin_b <= 1'b1;
    ship_mode <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial begin
    int n;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    check("limit reset", CCR_RST_LIMIT, limit);
    rd_check("three reset", CCR_OFS_CTRL_THREE, 8'h00);
    rd_check("four reset", CCR_OFS_CTRL_FOUR, 8'h21);
    wr(CCR_OFS_CTRL_THREE, 8'hff);
    rd_check("three reserved", CCR_OFS_CTRL_THREE, 8'h9d);
    wr(CCR_OFS_CTRL_THREE, 8'h00);
    wr(CCR_OFS_CTRL_FOUR, 8'hc0);
    rd_check("four drivers", CCR_OFS_CTRL_FOUR, 8'h40);
    check("driver one pin", 8'h01, {7'h00, drv_one});
    check("driver two pin", 8'h00, {7'h00, drv_two});
    wr(CCR_OFS_CTRL_THREE, 8'h80);
    rd_check("four drivers off", CCR_OFS_CTRL_FOUR, 8'h00);
    check("driver one forced", 8'h00, {7'h00, drv_one});
    wr(CCR_OFS_CTRL_FOUR, 8'h40);
    rd_check("four enable refused", CCR_OFS_CTRL_FOUR, 8'h00);
    wr(CCR_OFS_CTRL_THREE, 8'h15);
    wr(CCR_OFS_CTRL_FOUR, 8'h19);
    check("pins set", 8'hfc, pins);
    pulse_src(1'b1);
    rd_check("three watchdog", CCR_OFS_CTRL_THREE, 8'h11);
    rd_check("four watchdog", CCR_OFS_CTRL_FOUR, 8'h09);
    check("pins watchdog", 8'hac, pins);
    wr(CCR_OFS_CTRL_THREE, 8'h9d);
    wr(CCR_OFS_CTRL_FOUR, 8'h18);
    pulse_src(1'b0);
    rd_check("three reg reset", CCR_OFS_CTRL_THREE, 8'h80);
    rd_check("four reg reset", CCR_OFS_CTRL_FOUR, 8'h21);
    wr(8'h14, 8'hff);
    rd_check("unmapped", 8'h14, 8'h00);
    rd_check("four untouched", CCR_OFS_CTRL_FOUR, 8'h21);
    wr(CCR_OFS_CTRL_FOUR, 8'h03);
    rd_check("force refused", CCR_OFS_CTRL_FOUR, 8'h01);
    @(posedge clk);
    batt_ok <= 1'b1;
    repeat (3) @(posedge clk);
    wr(CCR_OFS_CTRL_FOUR, 8'h03);
    wait_for(0, 5, n);
    rd_check("force pending", CCR_OFS_CTRL_FOUR, 8'h03);
    check("limit held", 8'h00, limit);
    @(posedge clk);
    cur_zero <= 1'b1;
    wait_for(1, 8, n);
    @(posedge clk);
    adc_vbus <= 8'h5a;
    adc_done <= 1'b1;
    @(posedge clk);
    adc_done <= 1'b0;
    cur_zero <= 1'b0;
    wait_for(3, 5, n);
    check("limit updated", 8'h5a, limit);
    rd_check("force cleared", CCR_OFS_CTRL_FOUR, 8'h01);
    ship_try(8'h08, HOLD_S);
    ship_try(8'h00, HOLD_L);
    // second power-on with the strap low and both fet pairs fitted
    @(posedge clk);
    rst_b <= 1'b0;
    strap_pin <= 1'b0;
    pair_two <= 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    check("guard after reset", 8'h01, {7'h00, ocp_on});
    repeat (5) @(posedge clk);
    rd_check("four strap low", CCR_OFS_CTRL_FOUR, 8'h01);
    wr(CCR_OFS_CTRL_FOUR, 8'hc1);
    rd_check("four both drivers", CCR_OFS_CTRL_FOUR, 8'hc1);
    check("driver two present", 8'h01, {7'h00, drv_two});
    wr(CCR_OFS_CTRL_FOUR, 8'he1);
    pulse_src(1'b0);
    rd_check("rate back to strap", CCR_OFS_CTRL_FOUR, 8'hc1);
    print_verdict();
  end
endmodule
`default_nettype wire
